//--- rtl/sfd_ctl_decoder.sv
// What this block does
// - The received offset is placed in the block named by the control byte, which also fixes direction and length.
// - The block select field is control bits 7 down to 3, most significant at bit 7.
// - Bit 2 is the access direction and bits 1:0 the length mode, bit 1 upper.
// - There is one common block and eight sockets, and select zero means the common block.
// - Select four times socket plus one addresses that socket's registers.
// - Select four times socket plus two addresses that socket's transmit buffer.
// - Select four times socket plus three addresses that socket's receive buffer.
// - Socket 7 uses 11101, 11110 and 11111 in the same pattern.
// - Length mode picks a variable phase framed by chip select, or fixed 1, 2 or 4 bytes.
`timescale 1ns/1ps
module sfd_ctl_decoder
    import sfd_pkg::*;
(
    input  wire logic        clk,          // Core clock
    input  wire logic        reset_n,      // Sync reset, active low
    input  wire logic        sclk,         // Serial clock from host
    input  wire logic        cs_n,         // Chip select, active low
    input  wire logic        mosi,         // Serial data from host
    output logic             hdr_valid,    // Header decoded pulse
    output logic [15:0]      offset_addr,  // Offset within block
    output logic [4:0]       block_select, // Raw select field
    output logic [1:0]       block_kind,   // Common/reg/tx/rx
    output logic [2:0]       socket_num,   // Socket of the block
    output logic             access_direction, // 1 write, 0 read
    output logic [1:0]       length_mode,  // Raw length field
    output logic             variable_length_mode, // Chip select
    output logic [2:0]       data_len,     // Fixed bytes, 0 var
    output logic             common_sel,   // Common block picked
    output logic [7:0]       sock_reg_sel, // Socket registers
    output logic [7:0]       tx_buf_sel,   // Socket tx buffers
    output logic [7:0]       rx_buf_sel,   // Socket rx buffers
    output logic             reserved_sel, // Reserved select held
    output logic             reserved_seen,// Sticky reserved flag
    output logic             hdr_active,   // Selects are valid
    output logic             byte_stb,     // Data byte pulse
    output logic [7:0]       rx_byte,      // Last data byte
    output logic [15:0]      byte_count,   // Bytes in this access
    output logic             frame_end,    // Chip select rose
    output logic             short_frame   // Fixed access cut short
);

    typedef struct packed {
        logic [2:0]  hdr_sync;
        logic [2:0]  byte_sync;
        logic [2:0]  cs_sync;
        logic        hdr_valid;
        logic [15:0] offset_addr;
        logic [4:0]  block_select;
        logic [1:0]  block_kind;
        logic [2:0]  socket_num;
        logic        access_direction;
        logic [1:0]  length_mode;
        logic        variable_length_mode;
        logic [2:0]  data_len;
        logic        common_sel;
        logic [7:0]  sock_reg_sel;
        logic [7:0]  tx_buf_sel;
        logic [7:0]  rx_buf_sel;
        logic        reserved_sel;
        logic        reserved_seen;
        logic        hdr_active;
        logic        byte_stb;
        logic [7:0]  rx_byte;
        logic [15:0] byte_count;
        logic        frame_end;
        logic        short_frame;
    } sfd_core_t;

    sfd_core_t  core_ff;
    sfd_core_t  nxt_core;

    sfd_link_if lnk_if ();

    sfd_spi_link u_link (
        .sclk    (sclk),
        .reset_n (reset_n),
        .cs_n    (cs_n),
        .mosi    (mosi),
        .lnk     (lnk_if.link)
    );

    logic [HDR_BITS-1:0] hdr_word;
    logic [7:0]          ctrl_byte;
    logic [4:0]          sel_fld;
    logic [1:0]          kind;
    logic                is_common;
    logic                is_reserved;
    logic [7:0]          sock_match;
    logic                hdr_event;
    logic                byte_event;
    logic                cs_rise;

    assign hdr_word  = lnk_if.hdr;
    assign ctrl_byte = hdr_word[CTRL_BITS-1:0];
    assign sel_fld   = ctrl_byte[SEL_MSB:SEL_LSB];
    assign kind      = sel_fld[1:0];

    assign is_common   = (sel_fld == BLK_COMMON);
    // Reserved selects reach no block; the host must not send them
    assign is_reserved = !is_common && kind == KIND_BASE;

    // Socket number sits in the upper three select bits
    generate
        for (genvar s = 0; s < NUM_SOCKETS; s++) begin : g_sock
            assign sock_match[s] = (sel_fld[4:2] == 3'(s));
        end
    endgenerate

    // Events only from second stages and the stage after them
    assign hdr_event  = core_ff.hdr_sync[2] ^ core_ff.hdr_sync[1];
    assign byte_event = core_ff.byte_sync[2] ^ core_ff.byte_sync[1];
    assign cs_rise    = core_ff.cs_sync[1] & ~core_ff.cs_sync[2];

    always_comb begin
        nxt_core = core_ff;
        nxt_core.hdr_sync  = {core_ff.hdr_sync[1:0], lnk_if.hdr_tgl};
        nxt_core.byte_sync = {core_ff.byte_sync[1:0],
                              lnk_if.byte_tgl};
        nxt_core.cs_sync   = {core_ff.cs_sync[1:0], cs_n};
        nxt_core.hdr_valid   = 1'b0;
        nxt_core.byte_stb    = 1'b0;
        nxt_core.frame_end   = 1'b0;
        nxt_core.short_frame = 1'b0;

        if (byte_event && core_ff.hdr_active) begin
            nxt_core.byte_stb   = 1'b1;
            nxt_core.rx_byte    = lnk_if.rx_byte;
            nxt_core.byte_count = core_ff.byte_count + 16'h0001;
        end

        if (cs_rise) begin
            nxt_core.frame_end = 1'b1;
            // Last byte may sync in the same cycle as the edge
            if (core_ff.hdr_active &&
                !core_ff.variable_length_mode &&
                nxt_core.byte_count < 16'(core_ff.data_len)) begin
                nxt_core.short_frame = 1'b1;
            end
            nxt_core.hdr_active   = 1'b0;
            nxt_core.common_sel   = 1'b0;
            nxt_core.sock_reg_sel = 8'h00;
            nxt_core.tx_buf_sel   = 8'h00;
            nxt_core.rx_buf_sel   = 8'h00;
            nxt_core.reserved_sel = 1'b0;
        end

        // Word is held by the link until the next header completes
        if (hdr_event) begin
            nxt_core.hdr_valid   = 1'b1;
            nxt_core.hdr_active  = 1'b1;
            nxt_core.byte_count  = 16'h0000;
            nxt_core.offset_addr =
                hdr_word[HDR_BITS-1:CTRL_BITS];
            nxt_core.block_select = sel_fld;
            nxt_core.block_kind   = kind;
            nxt_core.socket_num   = sel_fld[4:2];
            nxt_core.access_direction =
                ctrl_byte[DIR_BIT] == DIR_WRITE;
            nxt_core.length_mode  =
                ctrl_byte[LEN_MSB:LEN_LSB];
            nxt_core.variable_length_mode =
                ctrl_byte[LEN_MSB:LEN_LSB] == LEN_VAR;
            nxt_core.data_len =
                sfd_len_bytes(ctrl_byte[LEN_MSB:LEN_LSB]);
            nxt_core.common_sel   = is_common;
            nxt_core.reserved_sel = is_reserved;
            if (is_reserved) begin
                nxt_core.reserved_seen = 1'b1;
            end
            nxt_core.sock_reg_sel =
                (kind == KIND_REG) ? sock_match : 8'h00;
            nxt_core.tx_buf_sel =
                (kind == KIND_TXBUF) ? sock_match : 8'h00;
            nxt_core.rx_buf_sel =
                (kind == KIND_RXBUF) ? sock_match : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            core_ff           <= '0;
            core_ff.cs_sync   <= SYNC_HIGH;
            core_ff.hdr_sync  <= SYNC_LOW;
            core_ff.byte_sync <= SYNC_LOW;
        end else begin
            core_ff <= nxt_core;
        end
    end

    assign hdr_valid            = core_ff.hdr_valid;
    assign offset_addr          = core_ff.offset_addr;
    assign block_select         = core_ff.block_select;
    assign block_kind           = core_ff.block_kind;
    assign socket_num           = core_ff.socket_num;
    assign access_direction     = core_ff.access_direction;
    assign length_mode          = core_ff.length_mode;
    assign variable_length_mode = core_ff.variable_length_mode;
    assign data_len             = core_ff.data_len;
    assign common_sel           = core_ff.common_sel;
    assign sock_reg_sel         = core_ff.sock_reg_sel;
    assign tx_buf_sel           = core_ff.tx_buf_sel;
    assign rx_buf_sel           = core_ff.rx_buf_sel;
    assign reserved_sel         = core_ff.reserved_sel;
    assign reserved_seen        = core_ff.reserved_seen;
    assign hdr_active           = core_ff.hdr_active;
    assign byte_stb             = core_ff.byte_stb;
    assign rx_byte              = core_ff.rx_byte;
    assign byte_count           = core_ff.byte_count;
    assign frame_end            = core_ff.frame_end;
    assign short_frame          = core_ff.short_frame;

endmodule : sfd_ctl_decoder

//--- rtl/sfd_pkg.sv
package sfd_pkg;

    // Serial header layout: 16 offset bits then the control byte
    localparam int ADDR_BITS = 16;
    localparam int CTRL_BITS = 8;
    localparam int HDR_BITS  = ADDR_BITS + CTRL_BITS;
    localparam logic [4:0] HDR_LAST = 5'h17;

    // Control byte field positions
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 3;
    localparam int DIR_BIT = 2;
    localparam int LEN_MSB = 1;
    localparam int LEN_LSB = 0;

    // Block select values and kinds (low two bits of the select)
    localparam int         NUM_SOCKETS = 8;
    localparam logic [4:0] BLK_COMMON  = 5'h00;
    localparam logic [1:0] KIND_BASE   = 2'h0;
    localparam logic [1:0] KIND_REG    = 2'h1;
    localparam logic [1:0] KIND_TXBUF  = 2'h2;
    localparam logic [1:0] KIND_RXBUF  = 2'h3;

    // Access direction
    localparam logic DIR_READ  = 1'b0;
    localparam logic DIR_WRITE = 1'b1;

    // Length modes and fixed data lengths in bytes
    localparam logic [1:0] LEN_VAR  = 2'h0;
    localparam logic [1:0] LEN_ONE  = 2'h1;
    localparam logic [1:0] LEN_TWO  = 2'h2;
    localparam logic [1:0] LEN_FOUR = 2'h3;
    localparam logic [2:0] BYTES_VAR  = 3'h0;
    localparam logic [2:0] BYTES_ONE  = 3'h1;
    localparam logic [2:0] BYTES_TWO  = 3'h2;
    localparam logic [2:0] BYTES_FOUR = 3'h4;

    // Reset values of the synchronisers
    localparam logic [2:0] SYNC_LOW  = 3'h0;
    localparam logic [2:0] SYNC_HIGH = 3'h7;

    function automatic logic [2:0] sfd_len_bytes(input logic [1:0] mode);
        case (mode)
            LEN_ONE:  sfd_len_bytes = BYTES_ONE;
            LEN_TWO:  sfd_len_bytes = BYTES_TWO;
            LEN_FOUR: sfd_len_bytes = BYTES_FOUR;
            default:  sfd_len_bytes = BYTES_VAR;
        endcase
    endfunction : sfd_len_bytes

endpackage : sfd_pkg

//--- rtl/sfd_link_if.sv
`timescale 1ns/1ps
interface sfd_link_if;
    import sfd_pkg::*;
    logic [HDR_BITS-1:0] hdr;      // Last complete header, held
    logic                hdr_tgl;  // Toggles per complete header
    logic [7:0]          rx_byte;  // Last data byte, held
    logic                byte_tgl; // Toggles per data byte

    modport link (output hdr, hdr_tgl, rx_byte, byte_tgl);
    modport core (input  hdr, hdr_tgl, rx_byte, byte_tgl);
endinterface : sfd_link_if

//--- rtl/sfd_spi_link.sv
`timescale 1ns/1ps
module sfd_spi_link
    import sfd_pkg::*;
(
    input  wire logic sclk,    // Serial clock from host
    input  wire logic reset_n, // Core reset, active low
    input  wire logic cs_n,    // Chip select, active low
    input  wire logic mosi,    // Serial data from host
    sfd_link_if.link  lnk      // Held words and toggles
);
    typedef enum logic {PH_HDR, PH_DATA} sfd_phase_t;

    typedef struct packed {
        sfd_phase_t  phase;
        logic [4:0]  bit_cnt;
        logic [22:0] shift;
        logic [2:0]  dbit;
        logic [2:0]  dbytes;
        logic [1:0]  mode;
    } sfd_frm_t;

    typedef struct packed {
        logic [HDR_BITS-1:0] hdr;
        logic                hdr_tgl;
        logic [7:0]          rx_byte;
        logic                byte_tgl;
    } sfd_lout_t;

    sfd_frm_t  frm_ff;
    sfd_frm_t  nxt_frm;
    sfd_lout_t out_ff;
    sfd_lout_t nxt_out;
    logic      frm_clr;

    // Sclk stops outside frames, so the frame ends by chip select
    assign frm_clr = cs_n | ~reset_n;

    always_comb begin
        nxt_frm = frm_ff;
        nxt_out = out_ff;
        nxt_frm.shift = {frm_ff.shift[21:0], mosi};
        case (frm_ff.phase)
            PH_HDR: begin
                nxt_frm.bit_cnt = frm_ff.bit_cnt + 5'h01;
                if (frm_ff.bit_cnt == HDR_LAST) begin
                    nxt_out.hdr     = {frm_ff.shift, mosi};
                    nxt_out.hdr_tgl = ~out_ff.hdr_tgl;
                    nxt_frm.mode    = {frm_ff.shift[0], mosi};
                    nxt_frm.phase   = PH_DATA;
                    nxt_frm.bit_cnt = 5'h00;
                    nxt_frm.dbit    = 3'h0;
                    nxt_frm.dbytes  = 3'h0;
                end
            end
            PH_DATA: begin
                nxt_frm.dbit = frm_ff.dbit + 3'h1;
                if (frm_ff.dbit == 3'h7) begin
                    nxt_out.rx_byte  = {frm_ff.shift[6:0], mosi};
                    nxt_out.byte_tgl = ~out_ff.byte_tgl;
                    nxt_frm.dbytes   = frm_ff.dbytes + 3'h1;
                    // Fixed lengths start the next header at once
                    if (frm_ff.mode != LEN_VAR &&
                        frm_ff.dbytes + 3'h1 ==
                        sfd_len_bytes(frm_ff.mode)) begin
                        nxt_frm.phase = PH_HDR;
                    end
                end
            end
            default: nxt_frm.phase = PH_HDR;
        endcase
    end

    always_ff @(posedge sclk or posedge frm_clr) begin
        if (frm_clr) begin
            frm_ff <= '0;
        end else begin
            frm_ff <= nxt_frm;
        end
    end

    // Toggles survive chip select so the core never sees a false event
    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign lnk.hdr      = out_ff.hdr;
    assign lnk.hdr_tgl  = out_ff.hdr_tgl;
    assign lnk.rx_byte  = out_ff.rx_byte;
    assign lnk.byte_tgl = out_ff.byte_tgl;

endmodule : sfd_spi_link

//--- bench/sfd_ctl_decoder_props.sv
`timescale 1ns/1ps
module sfd_ctl_decoder_props
    import sfd_pkg::*;
(
    input wire logic       clk,                  // Core clock
    input wire logic       reset_n,              // Sync reset
    input wire logic       hdr_valid,            // Header pulse
    input wire logic [15:0] offset_addr,         // Offset
    input wire logic [4:0] block_select,         // Select field
    input wire logic [1:0] block_kind,           // Kind
    input wire logic [2:0] socket_num,           // Socket
    input wire logic [1:0] length_mode,          // Length field
    input wire logic       variable_length_mode, // Var mode
    input wire logic [2:0] data_len,             // Fixed bytes
    input wire logic       common_sel,           // Common block
    input wire logic [7:0] sock_reg_sel,         // Socket regs
    input wire logic [7:0] tx_buf_sel,           // Tx buffers
    input wire logic [7:0] rx_buf_sel,           // Rx buffers
    input wire logic       reserved_sel,         // Reserved flag
    input wire logic       hdr_active,           // Selects valid
    input wire logic       byte_stb,             // Byte pulse
    input wire logic       frame_end,            // Frame end
    input wire logic       reserved_seen,        // Sticky reserved
    input wire logic       short_frame           // Cut fixed access
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    hdr_pulse_a: assert property (hdr_valid |=> !hdr_valid)
        else $error("header pulse longer than one cycle");
    field_split_a: assert property (hdr_valid |->
        block_kind == block_select[1:0] && socket_num == block_select[4:2])
        else $error("select field split wrong");
    common_map_a: assert property (hdr_valid |->
        common_sel == (block_select == 5'h00))
        else $error("common select wrong");
    sock_map_a: assert property (hdr_valid |-> sock_reg_sel ==
        (block_kind == 2'h1 ? 8'h01 << socket_num : 8'h00))
        else $error("socket register select wrong");
    tx_map_a: assert property (hdr_valid |-> tx_buf_sel ==
        (block_kind == 2'h2 ? 8'h01 << socket_num : 8'h00))
        else $error("tx buffer select wrong");
    rx_map_a: assert property (hdr_valid |-> rx_buf_sel ==
        (block_kind == 2'h3 ? 8'h01 << socket_num : 8'h00))
        else $error("rx buffer select wrong");
    reserved_map_a: assert property (hdr_valid |-> reserved_sel ==
        (block_select != 5'h00 && block_kind == 2'h0))
        else $error("reserved flag wrong");
    len_decode_a: assert property (hdr_valid |->
        variable_length_mode == (length_mode == 2'h0) && data_len ==
        (length_mode == 2'h3 ? 3'h4 : {1'b0, length_mode}))
        else $error("length decode wrong");
    frame_clear_a: assert property (frame_end && !hdr_valid |->
        ##[0:1] (!hdr_active && !common_sel))
        else $error("selects not cleared at frame end");
    offset_hold_a: assert property (
        !hdr_valid |-> $stable(offset_addr))
        else $error("offset changed without header");
    // Last byte may strobe as the frame end clears the flag
    byte_after_a: assert property (byte_stb |-> $past(hdr_active))
        else $error("data byte without header");
    seen_sticky_a: assert property (
        reserved_sel || $past(reserved_seen) |-> reserved_seen)
        else $error("reserved flag not sticky");
    short_flag_a: assert property (short_frame |-> frame_end &&
        $past(hdr_active) && !$past(variable_length_mode))
        else $error("short frame flag without fixed access");
endmodule : sfd_ctl_decoder_props

bind sfd_ctl_decoder sfd_ctl_decoder_props u_props (
    .clk, .reset_n, .hdr_valid, .offset_addr, .block_select, .block_kind,
    .socket_num, .length_mode, .variable_length_mode, .data_len,
    .common_sel, .sock_reg_sel, .tx_buf_sel, .rx_buf_sel, .reserved_sel,
    .hdr_active, .byte_stb, .frame_end, .reserved_seen, .short_frame
);

//--- bench/sfd_host_model.sv
`timescale 1ns/1ps
module sfd_host_model (
    output logic sclk, // Serial clock, idle low
    output logic cs_n, // Chip select
    output logic mosi  // Serial data
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic start();
        cs_n = 1'b0;
        #15;
    endtask : start

    // Mode 0, MSB first; data moves only while sclk is low
    task automatic shift(input logic [23:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            mosi = v[i];
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
    endtask : shift

    // Released line shows no stale bit
    task automatic stop();
        #15 cs_n = 1'b1;
        mosi = ~mosi;
    endtask : stop
endmodule : sfd_host_model

//--- bench/test_sfd_ctl_decoder.sv
`timescale 1ns/1ps
module test_sfd_ctl_decoder;
    import sfd_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        sclk, cs_n, mosi;
    logic        hdr_valid, access_direction, variable_length_mode;
    logic        common_sel, reserved_sel, byte_stb;
    logic [15:0] offset_addr, byte_count;
    logic [4:0]  block_select;
    logic [1:0]  length_mode;
    logic [2:0]  data_len;
    logic [7:0]  sock_reg_sel, tx_buf_sel, rx_buf_sel, rx_byte, c;
    logic [53:0] hq[$];
    logic [23:0] bq[$];
    int          fail_count = 0;
    int          samples_checked = 0;
    int          seed = 49875;
    int          cycles = 0;
    int          n;

    always #20 clk = ~clk;

    sfd_host_model u_host (.sclk, .cs_n, .mosi);

    sfd_ctl_decoder u_dut (
        .clk, .reset_n, .sclk, .cs_n, .mosi, .hdr_valid, .offset_addr,
        .block_select, .block_kind(), .socket_num(), .access_direction,
        .length_mode, .variable_length_mode, .data_len, .common_sel,
        .sock_reg_sel, .tx_buf_sel, .rx_buf_sel, .reserved_sel,
        .reserved_seen(), .hdr_active(), .byte_stb, .rx_byte, .byte_count,
        .frame_end(), .short_frame()
    );

    function automatic logic [53:0] exp_hdr(input logic [15:0] off,
                                            input logic [7:0] k);
        logic [4:0] b;
        logic [7:0] oh;
        logic [2:0] dl;
        b = k[7:3];
        oh = 8'h01 << b[4:2];
        dl = (k[1:0] == 2'h3) ? 3'h4 : {1'b0, k[1:0]};
        exp_hdr = {off, b, k[2], k[1:0], k[1:0] == 2'h0, dl, b == 5'h00,
                   b[1:0] == 2'h1 ? oh : 8'h00, b[1:0] == 2'h2 ? oh : 8'h00,
                   b[1:0] == 2'h3 ? oh : 8'h00,
                   b != 5'h00 && b[1:0] == 2'h0};
    endfunction : exp_hdr

    task automatic conclude();
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic cmp_hdr(input logic [53:0] got, input logic [53:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_hdr

    task automatic cmp_byte(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_byte

    // Header then its data bytes; expectations noted before shifting
    task automatic frame(input logic [15:0] off, input logic [7:0] k,
                         input int nb);
        logic [7:0] d;
        hq.push_back(exp_hdr(off, k));
        u_host.shift({off, k}, 24);
        for (int i = 1; i <= nb; i++) begin
            d = 8'($random(seed));
            bq.push_back({d, 16'(i)});
            u_host.shift({16'h0000, d}, 8);
        end
    endtask : frame

    always @(negedge clk) begin
        if (hdr_valid === 1'b1)
            cmp_hdr({offset_addr, block_select, access_direction, length_mode,
                     variable_length_mode, data_len, common_sel, sock_reg_sel,
                     tx_buf_sel, rx_buf_sel, reserved_sel},
                    hq.pop_front());
        if (byte_stb === 1'b1)
            cmp_byte({rx_byte, byte_count}, bq.pop_front());
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        // Every select, reserved ones included, with all length modes
        for (int s = 0; s < 32; s++) begin
            c = {5'(s), 1'($random(seed)), 2'(s ^ (s >> 2))};
            n = (c[1:0] == 2'h0) ? 2 : (c[1:0] == 2'h3 ? 4 : int'(c[1:0]));
            if (c[4:3] == 2'h0 && s != 0)
                n = 0;
            u_host.start();
            frame(16'($random(seed)), c, n);
            u_host.stop();
            repeat (8) @(negedge clk);
        end
        // Fixed lengths back to back under one chip select
        u_host.start();
        frame(16'hffff, 8'hed, 1);
        frame(16'h0000, 8'hf2, 2);
        frame(16'h8001, 8'hff, 4);
        u_host.stop();
        repeat (20) @(negedge clk);
        if (hq.size() != 0 || bq.size() != 0)
            fail_count++;
        conclude();
    end
endmodule : test_sfd_ctl_decoder
